// ===== core/kms_scanner.v
`timescale 1ns/1ps
`include "kms_defines.vh"

module kms_scanner #(
  parameter UNIT_CYCLES = `KMS_UNIT_NS / `KMS_CLK_PERIOD_NS
) (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output wire [31:0] hrdata_out,
  output wire hreadyout_out,
  output wire hresp_out,
  input wire [7:0] scan_row_input_in,
  output wire [7:0] row_pullup_en_out,
  output wire [15:0] keypad_column_line_out,
  output wire [15:0] keypad_column_line_oe_n_out,
  output wire [15:0] column_pullup_en_out,
  input wire power_down_in,
  output wire external_irq_one_out,
  output wire wake_reset_req_out
);

  localparam ST_IDLE = 2'h0;
  localparam ST_DRIVE = 2'h1;
  localparam ST_GAP = 2'h2;
  // Cut to the counter width on purpose; the unit count always fits
  localparam integer TICK_LAST_I = UNIT_CYCLES - 1;
  localparam [`KMS_TICK_W-1:0] TICK_LAST = TICK_LAST_I[`KMS_TICK_W-1:0];

  // Scan step to pin index; pins 0 to 3 and 13 carry no column
  function [3:0] kms_col_pin;
    input [3:0] step;
    begin
      if (step < 4'h4) begin
        kms_col_pin = step + 4'h4;
      end else if (step < 4'h9) begin
        kms_col_pin = step + 4'h4;
      end else begin
        kms_col_pin = step + 4'h5;
      end
    end
  endfunction

  function [5:0] kms_word;
    input [7:0] addr;
    begin
      kms_word = addr[7:2];
    end
  endfunction

  reg [7:0] row_meta_r;
  reg [7:0] row_sync_r;
  reg [2:0] ctrl_r;
  reg [15:0] thresh_r;
  reg st_press_r;
  reg st_release_r;
  reg [7:0] last_r;
  reg [31:0] hrdata_r;
  reg hreadyout_r;
  reg wr_pend_r;
  reg rd_pend_r;
  reg [7:0] addr_r;
  reg [1:0] state_r;
  reg [3:0] step_r;
  reg [7:0] settle_r;
  reg [`KMS_KEYS-1:0] raw_r;
  reg [`KMS_TICK_W-1:0] tick_cnt_r;
  reg tick_r;
  reg [15:0] col_oe_n_r;
  reg [7:0] row_pu_r;
  reg irq_r;
  reg wake_r;
  wire [`KMS_KEYS-1:0] deb_w;
  wire [`KMS_KEYS-1:0] press_hit;
  wire [`KMS_KEYS-1:0] rel_hit;
  wire scan_en = ctrl_r[`KMS_CTRL_SCAN_BIT];
  wire wake_en = ctrl_r[`KMS_CTRL_WAKE_BIT];
  wire irq_en = ctrl_r[`KMS_CTRL_IRQ_BIT];
  wire any_press = |press_hit;
  wire any_rel = |rel_hit;
  wire addr_ok = hsel_in & htrans_in[1] & hready_in;

  // Rows are asynchronous pins; the first stage feeds only the second
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      row_meta_r <= 8'hff;
      row_sync_r <= 8'hff;
    end else begin
      row_meta_r <= scan_row_input_in;
      row_sync_r <= row_meta_r;
    end
  end

  // Debounce time base: one pulse per 2 ms unit
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt_r <= {`KMS_TICK_W{1'b0}};
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= {`KMS_TICK_W{1'b0}};
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // Walking zero: drive one column, let it settle past the row synchroniser, sample, release
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ST_IDLE;
      step_r <= 4'h0;
      settle_r <= 8'h00;
      raw_r <= {`KMS_KEYS{1'b0}};
      col_oe_n_r <= 16'hffff;
    end else if (power_down_in) begin
      state_r <= ST_IDLE;
      step_r <= 4'h0;
      // Sleep with wake enabled: all columns low so any key pulls its row down; otherwise all released
      col_oe_n_r <= wake_en ? 16'b1101_1111_1111_0000 ^ 16'hffff : 16'hffff;
    end else begin
      case (state_r)
        ST_IDLE: begin
          col_oe_n_r <= 16'hffff;
          if (scan_en) begin
            state_r <= ST_DRIVE;
            step_r <= 4'h0;
            settle_r <= `KMS_SETTLE_CYCLES;
            col_oe_n_r <= ~(16'h0001 << kms_col_pin(4'h0));
          end
        end
        ST_DRIVE: begin
          if (settle_r == 8'h00) begin
            // A pressed key shorts the low column onto its row
            raw_r[step_r*8 +: 8] <= ~row_sync_r;
            col_oe_n_r <= 16'hffff;
            state_r <= ST_GAP;
          end else begin
            settle_r <= settle_r - 8'h01;
          end
        end
        ST_GAP: begin
          if (!scan_en) begin
            state_r <= ST_IDLE;
          end else begin
            step_r <= (step_r == 4'ha) ? 4'h0 : step_r + 4'h1;
            settle_r <= `KMS_SETTLE_CYCLES;
            col_oe_n_r <= ~(16'h0001 << kms_col_pin((step_r == 4'ha) ? 4'h0 : step_r + 4'h1));
            state_r <= ST_DRIVE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          col_oe_n_r <= 16'hffff;
        end
      endcase
    end
  end

  // Per-key filter: a change must hold for its threshold in 2 ms units; any bounce restarts it
  genvar g;
  generate
    for (g = 0; g < `KMS_KEYS; g = g + 1) begin : key_flt
      reg deb_r;
      reg [7:0] cnt_r;
      wire [7:0] thr = raw_r[g] ? thresh_r[15:8] : thresh_r[7:0];
      wire settled = (raw_r[g] != deb_r) && (cnt_r >= thr);
      assign deb_w[g] = deb_r;
      assign press_hit[g] = settled & raw_r[g];
      assign rel_hit[g] = settled & ~raw_r[g];
      always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          deb_r <= 1'b0;
          cnt_r <= 8'h00;
        end else if (raw_r[g] != deb_r) begin
          if (cnt_r >= thr) begin
            deb_r <= raw_r[g];
            cnt_r <= 8'h00;
          end else if (tick_r) begin
            cnt_r <= cnt_r + 8'h01;
          end
        end else begin
          cnt_r <= 8'h00;
        end
      end
    end
  endgenerate

  // Lowest key index with an event this cycle, and number of keys held
  integer k;
  reg [6:0] ev_code;
  reg ev_press;
  reg [6:0] held_cnt;
  always @* begin
    ev_code = 7'h00;
    ev_press = 1'b0;
    held_cnt = 7'h00;
    for (k = `KMS_KEYS - 1; k >= 0; k = k - 1) begin
      if (press_hit[k] | rel_hit[k]) begin
        ev_code = k[6:0];
        ev_press = press_hit[k];
      end
      held_cnt = held_cnt + {6'h00, deb_w[k]};
    end
  end

  // Bus slave: writes with no wait, reads with one wait state so a write just before is seen
  wire wr_go = wr_pend_r;
  wire [5:0] wr_word = kms_word(addr_r);
  wire st_clr_press = wr_go && wr_word == kms_word(`KMS_REG_STATUS) &&
    hwdata_in[`KMS_ST_PRESS_BIT];
  wire st_clr_rel = wr_go && wr_word == kms_word(`KMS_REG_STATUS) &&
    hwdata_in[`KMS_ST_RELEASE_BIT];

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hreadyout_r <= 1'b1;
    end else begin
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        hreadyout_r <= 1'b1;
      end else if (addr_ok && !hwrite_in) begin
        rd_pend_r <= 1'b1;
        hreadyout_r <= 1'b0;
      end
      wr_pend_r <= addr_ok & hwrite_in;
      if (addr_ok) begin
        addr_r <= haddr_in[7:0];
      end
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r <= `KMS_CTRL_RESET;
      thresh_r <= `KMS_THRESH_RESET;
      st_press_r <= 1'b0;
      st_release_r <= 1'b0;
      last_r <= 8'h00;
    end else begin
      if (wr_go && wr_word == kms_word(`KMS_REG_CTRL)) begin
        ctrl_r <= hwdata_in[2:0];
      end
      if (wr_go && wr_word == kms_word(`KMS_REG_THRESH)) begin
        thresh_r <= hwdata_in[15:0];
      end
      // A new event in the clearing cycle keeps its flag
      st_press_r <= (st_press_r & ~st_clr_press) | any_press;
      st_release_r <= (st_release_r & ~st_clr_rel) | any_rel;
      if (any_press | any_rel) begin
        last_r <= {ev_press, ev_code};
      end
    end
  end

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (kms_word(addr_r))
      kms_word(`KMS_REG_CTRL): rd_mux = {29'h0, ctrl_r};
      kms_word(`KMS_REG_THRESH): rd_mux = {16'h0000, thresh_r};
      kms_word(`KMS_REG_STATUS): rd_mux = {21'h0, held_cnt, 2'h0, st_release_r, st_press_r};
      kms_word(`KMS_REG_KEYS0): rd_mux = deb_w[31:0];
      kms_word(`KMS_REG_KEYS1): rd_mux = deb_w[63:32];
      kms_word(`KMS_REG_KEYS2): rd_mux = {8'h00, deb_w[87:64]};
      kms_word(`KMS_REG_LAST): rd_mux = {24'h0, last_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata_r <= rd_mux;
    end
  end

  // Interrupt line, pull-ups and wake request
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      row_pu_r <= 8'h00;
    end else begin
      irq_r <= irq_en & (st_press_r | st_release_r);
      wake_r <= power_down_in & wake_en & ~(&row_sync_r);
      row_pu_r <= 8'hff;
    end
  end

  assign hrdata_out = hrdata_r;
  assign hreadyout_out = hreadyout_r;
  assign hresp_out = 1'b0;
  assign row_pullup_en_out = row_pu_r;
  assign keypad_column_line_out = 16'h0000;
  assign keypad_column_line_oe_n_out = col_oe_n_r;
  assign column_pullup_en_out = col_oe_n_r & 16'b1101_1111_1111_0000;
  assign external_irq_one_out = irq_r;
  assign wake_reset_req_out = wake_r;

endmodule // kms_scanner

// ===== pkg/kms_defines.vh
// Notes on behaviour
// - The scanner covers a switch array of 8 rows by 11 columns, at most 88 keys.
// - Eleven pins serve as column outputs and eight pins as row inputs with pull-ups.
// - Every row line is held high by a pull-up while it is sampled.
// - Each column line is either driven low or resistively pulled high.
// - A low on a column shows as a low on every row joined to it by a pressed key.
// - A single low steps across the columns and the rows are sampled at each step.
// - At least two and up to eight keys held together are resolved.
// - Detected key activity is latched and raises an interrupt request.
// - Each press and each release gives its own interrupt notification; in the code, events before a clear share one sticky press or release flag.
// - Glitches and too rapid changes are rejected; only stable transitions are reported.
// - Glitch blackout and minimum press thresholds are set in units of 2 ms.
// - With the wake option enabled, any key press wakes the chip from sleep.
// - Columns sit on pin indices four to seven, eight to twelve and fourteen to fifteen.
// - Scanner interrupts go out on the shared external interrupt one, vector 2.
// - In power-down, any row held low raises a maskable wake-up reset request.
`ifndef KMS_DEFINES_VH
`define KMS_DEFINES_VH

`define KMS_ROWS 8
`define KMS_COLS 11
`define KMS_KEYS 88
`define KMS_PINS 16
`define KMS_IRQ_VECTOR 4'h2

`define KMS_CLK_PERIOD_NS 5
`define KMS_UNIT_NS 2000000
`define KMS_TICK_W 19
`define KMS_SETTLE_CYCLES 8'h10

`define KMS_REG_CTRL 8'h00
`define KMS_REG_THRESH 8'h04
`define KMS_REG_STATUS 8'h08
`define KMS_REG_KEYS0 8'h0c
`define KMS_REG_KEYS1 8'h10
`define KMS_REG_KEYS2 8'h14
`define KMS_REG_LAST 8'h18

`define KMS_CTRL_SCAN_BIT 0
`define KMS_CTRL_WAKE_BIT 1
`define KMS_CTRL_IRQ_BIT 2
`define KMS_CTRL_RESET 3'h0
`define KMS_THRESH_RESET 16'h0202
`define KMS_ST_PRESS_BIT 0
`define KMS_ST_RELEASE_BIT 1
`define KMS_ST_COUNT_LSB 4

`endif

// ===== verification/kms_key_matrix.sv
`timescale 1ns/1ps
module kms_key_matrix (
  input wire logic [15:0] col_oe_n_in,
  input wire logic [87:0] keys_in,
  output logic [7:0] rows_out
);
  // Column step to pin; pins 0-3 and 13 carry no column
  localparam logic [3:0] PIN [0:10] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc,
    4'he, 4'hf};
  always_comb begin
    rows_out = 8'hff;
    for (int c = 0; c < 11; c++) begin
      for (int r = 0; r < 8; r++) begin
        if (!col_oe_n_in[PIN[c]] && keys_in[c*8+r]) rows_out[r] = 1'b0;
      end
    end
  end
endmodule // kms_key_matrix

// ===== verification/kms_scanner_assertions.sv
`timescale 1ns/1ps
module kms_scanner_assertions (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire hsel_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire hready_in,
  input wire hreadyout_out,
  input wire hresp_out,
  input wire [7:0] row_pullup_en_out,
  input wire [15:0] keypad_column_line_out,
  input wire [15:0] keypad_column_line_oe_n_out,
  input wire [15:0] column_pullup_en_out,
  input wire power_down_in,
  input wire wake_reset_req_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  AST_ONE_COL: assert property (
    !power_down_in [*3] |-> $onehot0(~keypad_column_line_oe_n_out))
    else $error("more than one column low");
  AST_PIN_GROUPS: assert property (
    keypad_column_line_oe_n_out[3:0] == 4'hf && keypad_column_line_oe_n_out[13])
    else $error("column driven on unused pin");
  AST_LOW_ONLY: assert property (keypad_column_line_out == 16'h0)
    else $error("column value not low");
  AST_COL_PULL: assert property (
    column_pullup_en_out == (keypad_column_line_oe_n_out & 16'hdff0))
    else $error("column pull-up wrong");
  AST_ROW_PULL: assert property ($past(arst_n_in) |-> row_pullup_en_out == 8'hff)
    else $error("row pull-up off");
  AST_STEP: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in || power_down_in)
    $fell(keypad_column_line_oe_n_out[5]) |-> ##16 !keypad_column_line_oe_n_out[5] ##1
    &keypad_column_line_oe_n_out)
    else $error("column step length wrong");
  AST_WAKE_PD: assert property (wake_reset_req_out |-> $past(power_down_in))
    else $error("wake request outside power-down");
  AST_READ_WAIT: assert property (hsel_in && htrans_in[1] && !hwrite_in && hready_in |=>
    !hreadyout_out ##1 hreadyout_out) else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (hsel_in && htrans_in[1] && hwrite_in && hready_in |=>
    hreadyout_out && !hresp_out) else $error("write stalled");
endmodule // kms_scanner_assertions

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} kms_row_t;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0, hsel = 1'b0, hwrite = 1'b0, pd = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [87:0] keys = 88'h0;
  wire [31:0] hrdata;
  wire hready, hresp, irq, wake;
  wire [7:0] rows, rpu;
  wire [15:0] col, oe_n, cpu;
  int n_fail = 0, checks = 0;
  kms_row_t tbl [0:6] = '{'{8'h00, 1'b0, 32'h0, 32'h0}, '{8'h04, 1'b0, 32'h0, 32'h0202},
    '{8'h08, 1'b0, 32'h0, 32'h0}, '{8'h0c, 1'b0, 32'h0, 32'h0}, '{8'h1c, 1'b0, 32'h0, 32'h0},
    '{8'h1c, 1'b1, 32'hffffffff, 32'h0}, '{8'h00, 1'b1, 32'h5, 32'h5}};
  always #2.5 clk_sys_in = ~clk_sys_in;
  kms_scanner #(.UNIT_CYCLES(8)) uut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .scan_row_input_in(rows), .row_pullup_en_out(rpu),
    .keypad_column_line_out(col), .keypad_column_line_oe_n_out(oe_n),
    .column_pullup_en_out(cpu), .power_down_in(pd), .external_irq_one_out(irq),
    .wake_reset_req_out(wake));
  kms_key_matrix u_keys (.col_oe_n_in(oe_n), .keys_in(keys), .rows_out(rows));
  task stop_test;
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  initial begin
    wt(12);
    chk("oe_n reset", 32'hffff, {16'h0, oe_n});
    arst_n_in <= 1'b1;
    wt(1);
    foreach (tbl[i]) begin
      if (tbl[i].w) bus(1'b1, tbl[i].a, tbl[i].d);
      rdchk("reg", tbl[i].a, tbl[i].e);
    end
    keys <= (88'h1 << 87) | (88'h1 << 13) | 88'h1;
    wt(1200);
    rdchk("keys0", 8'h0c, 32'h2001);
    rdchk("keys2", 8'h14, 32'h00800000);
    rdchk("status", 8'h08, 32'h31);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, 8'h08, 32'h3);
    wt(3);
    rdchk("status clr", 8'h08, 32'h30);
    chk("irq clr", 32'h0, {31'h0, irq});
    keys[13] <= 1'b0;
    wt(1200);
    rdchk("status rel", 8'h08, 32'h22);
    rdchk("last", 8'h18, 32'h0d);
    chk("irq rel", 32'h1, {31'h0, irq});
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h04, 32'h4002);
    keys[40] <= 1'b1;
    wt(250);
    keys[40] <= 1'b0;
    wt(1200);
    rdchk("glitch keys1", 8'h10, 32'h0);
    rdchk("glitch status", 8'h08, 32'h20);
    bus(1'b1, 8'h00, 32'h7);
    pd <= 1'b1;
    wt(10);
    chk("wake", 32'h1, {31'h0, wake});
    chk("pd cols", 32'h200f, {16'h0, oe_n});
    pd <= 1'b0;
    bus(1'b1, 8'h00, 32'h5);
    pd <= 1'b1;
    wt(10);
    chk("wake masked", 32'h0, {31'h0, wake});
    pd <= 1'b0;
    wt(400);
    arst_n_in <= 1'b0;
    wt(2);
    chk("oe_n rst", 32'hffff, {16'h0, oe_n});
    chk("irq rst", 32'h0, {31'h0, irq});
    arst_n_in <= 1'b1;
    wt(2);
    rdchk("ctrl rst", 8'h00, 32'h0);
    rdchk("status rst", 8'h08, 32'h0);
    chk("oe_n idle", 32'hffff, {16'h0, oe_n});
    stop_test;
  end
  initial begin
    wt(20000);
    n_fail++;
    stop_test;
  end
endmodule // tb_top
bind kms_scanner kms_scanner_assertions u_chk (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
  .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .row_pullup_en_out(row_pullup_en_out),
  .keypad_column_line_out(keypad_column_line_out), .power_down_in(power_down_in),
  .keypad_column_line_oe_n_out(keypad_column_line_oe_n_out),
  .column_pullup_en_out(column_pullup_en_out), .wake_reset_req_out(wake_reset_req_out));
